// ---- vofl_pkg.sv ----
/*
 * Shared constants and types of the video output FIFO flag block: register map,
 * control layout, interrupt bits, timing figures and the port carriers.
 * Assumes a single 40 MHz system clock and a plain strobe register port.
 */
package vofl_pkg;

	// ***********************************************************************
	// Widths and depths
	// ***********************************************************************
	localparam int PIX_W = 20;
	localparam int FIFO_DEPTH = 32;
	localparam int PTR_W = 5;
	localparam int LVL_W = 6;
	localparam int MARGIN_W = 5;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int GENLOCK_W = 24;
	localparam int GENLOCK_CNT_W = 5;
	localparam int NCO_W = 16;
	localparam logic [LVL_W-1:0] LVL_EMPTY = 6'h00;
	localparam logic [LVL_W-1:0] LVL_FULL = 6'h20;
	localparam logic [LVL_W-1:0] LVL_HALF = 6'h10;
	localparam logic [LVL_W-1:0] LVL_ONE = 6'h01;
	localparam logic [GENLOCK_CNT_W-1:0] GENLOCK_LAST = 5'h17;

	// ***********************************************************************
	// Timing
	// ***********************************************************************
	localparam int MCLK_FREQ_KHZ = 40000;
	localparam int LLC_FREQ_KHZ = 27000;
	localparam logic [NCO_W:0] NCO_MOD = 17'(MCLK_FREQ_KHZ);
	localparam logic [NCO_W:0] NCO_STEP = 17'(LLC_FREQ_KHZ);

	// ***********************************************************************
	// Input synchroniser lanes
	// ***********************************************************************
	localparam int SYNC_N = 3;
	localparam int SYNC_RDCLK = 0;
	localparam int SYNC_POWER = 1;
	localparam int SYNC_PIN = 2;
	localparam logic [SYNC_N-1:0] SYNC_RESET = 3'h2;

	// ***********************************************************************
	// Register map
	// ***********************************************************************
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_INT_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h0C;
	localparam int CTRL_W = 10;
	localparam int INT_W = 4;
	localparam int INT_OVERFLOW = 0;
	localparam int INT_UNDERFLOW = 1;
	localparam int INT_NEAR_FULL = 2;
	localparam int INT_NEAR_EMPTY = 3;
	localparam int STAT_W = 11;

	typedef enum logic [1:0] {
		VOFL_MODE_GENLOCK = 2'h0,
		VOFL_MODE_QUAL = 2'h1,
		VOFL_MODE_HALF = 2'h2,
		VOFL_MODE_RSVD = 2'h3
	} vofl_mode_t;

	typedef enum logic {
		VOFL_PWR_RUN = 1'h0,
		VOFL_PWR_DOWN = 1'h1
	} vofl_pwr_t;

	// Layout matches control register bits [9:0]
	typedef struct packed {
		logic fifo_clock_mode;
		logic qualifier_polarity_select;
		vofl_mode_t output_mode_select;
		logic flag_polarity_select;
		logic [MARGIN_W-1:0] fifo_margin_level;
	} vofl_ctrl_t;

	localparam vofl_ctrl_t CTRL_RESET = 10'h1A4;

	// ***********************************************************************
	// Carriers
	// ***********************************************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} vofl_bus_req_t;

	typedef struct packed {
		logic push;
		logic [PIX_W-1:0] data;
	} vofl_pix_t;

	typedef struct packed {
		logic fifo_near_full_flag;
		logic fifo_near_empty_flag;
		logic multi_pin;
		logic multi_oe;
		logic half_rate_qualifier;
		logic half_line_locked_clock;
		logic line_locked_clock;
	} vofl_pins_t;

	localparam vofl_pins_t PINS_RESET = 7'h28;

endpackage : vofl_pkg

// ---- vofl_sync.sv ----
/*
 * Three-stage synchroniser for the pins that arrive from outside the clock domain.
 * Assumes nothing of the source; the output changes once stages two and three agree.
 */
module vofl_sync (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// Raw pins and filtered levels
	input wire logic [vofl_pkg::SYNC_N-1:0] i_raw,
	output logic [vofl_pkg::SYNC_N-1:0] o_level
);
	import vofl_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} vofl_sync_t;

	// ***********************************************************************
	// One lane per pin
	// ***********************************************************************
	genvar g;
	generate
		for (g = 0; g < SYNC_N; g++) begin : g_lane
			vofl_sync_t st;
			vofl_sync_t next_st;

			always_comb begin
				next_st = st;
				next_st.s1 = i_raw[g];
				next_st.s2 = st.s1;
				next_st.s3 = st.s2;
				// Stage one feeds stage two only, so metastability stays contained
				if (st.s2 == st.s3) begin
					next_st.level = st.s2;
				end
			end

			always_ff @(posedge i_mclk) begin
				if (i_srst) begin
					st <= {4{SYNC_RESET[g]}};
				end else begin
					st <= next_st;
				end
			end

			assign o_level[g] = st.level;
		end
	endgenerate

endmodule : vofl_sync

// ---- vofl_top.sv ----
/*
 * Video output FIFO with near-full, near-empty and half-level flags, the shared
 * multifunction pin, line-locked clock outputs and power-down control.
 * Assumes the read clock and power-down pin are asynchronous and that pixel pushes
 * and register strobes come from logic on i_mclk.
 */
// Design decisions made here: the placing of the registers and the plain strobed port.
module vofl_top (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// Register port
	input wire vofl_pkg::vofl_bus_req_t i_bus,
	output logic [vofl_pkg::DATA_W-1:0] o_rdata,
	output logic o_irq,
	// Pixel source
	input wire vofl_pkg::vofl_pix_t i_pix,
	input wire logic [vofl_pkg::GENLOCK_W-1:0] i_genlock_word,
	// External pins
	input wire logic i_fifo_read_clock,
	input wire logic i_power_down_n,
	input wire logic i_multi_pin,
	output logic [vofl_pkg::PIX_W-1:0] o_pixel_output_bus,
	output vofl_pkg::vofl_pins_t o_pins
);
	import vofl_pkg::*;

	typedef struct packed {
		logic [FIFO_DEPTH-1:0][PIX_W-1:0] mem;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [LVL_W-1:0] level;
		vofl_ctrl_t ctrl;
		logic [INT_W-1:0] int_stat;
		logic [INT_W-1:0] int_mask;
		logic [DATA_W-1:0] rdata;
		logic irq;
		logic rd_clk_prev;
		logic nf;
		logic ne;
		logic hf;
		logic [NCO_W-1:0] nco;
		logic [GENLOCK_W-1:0] genlock_shift;
		logic [GENLOCK_CNT_W-1:0] genlock_cnt;
		vofl_pwr_t pwr;
		vofl_pins_t pins;
		logic [PIX_W-1:0] pix_out;
	} vofl_state_t;

	vofl_state_t st;
	vofl_state_t next_st;
	logic [SYNC_N-1:0] sync_lvl;
	logic rd_rise;
	logic pop;
	logic push;
	logic tick;
	logic down;
	logic [NCO_W:0] nco_sum;
	logic [LVL_W-1:0] nf_level;
	logic [INT_W-1:0] events;
	logic [STAT_W-1:0] status;

	// ***********************************************************************
	// Pin synchronisers
	// ***********************************************************************
	vofl_sync u_sync (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_raw({i_multi_pin, i_power_down_n, i_fifo_read_clock}),
		.o_level(sync_lvl)
	);

	// ***********************************************************************
	// Next state
	// ***********************************************************************
	always_comb begin
		next_st = st;
		down = ~sync_lvl[SYNC_POWER];
		rd_rise = sync_lvl[SYNC_RDCLK] & ~st.rd_clk_prev;
		next_st.rd_clk_prev = sync_lvl[SYNC_RDCLK];
		// Reads that find the FIFO empty are counted as underflow, not served
		pop = rd_rise & (st.level != LVL_EMPTY) & ~down;
		push = i_pix.push & (st.level != LVL_FULL) & ~down;
		events = '0;
		events[INT_OVERFLOW] = i_pix.push & (st.level == LVL_FULL) & ~down;
		events[INT_UNDERFLOW] = rd_rise & (st.level == LVL_EMPTY) & ~down;

		// FIFO storage and read side
		if (push) begin
			next_st.mem[st.wr_ptr] = i_pix.data;
			next_st.wr_ptr = PTR_W'(st.wr_ptr + 1'b1);
		end
		if (pop) begin
			next_st.pix_out = st.mem[st.rd_ptr];
			next_st.rd_ptr = PTR_W'(st.rd_ptr + 1'b1);
		end
		if (push && !pop) begin
			next_st.level = LVL_W'(st.level + LVL_ONE);
		end else if (pop && !push) begin
			next_st.level = LVL_W'(st.level - LVL_ONE);
		end

		// Flags are re-evaluated only on a read clock edge; power-down forces them to their empty values
		nf_level = LVL_W'(LVL_FULL - {1'b0, st.ctrl.fifo_margin_level});
		if (rd_rise) begin
			next_st.nf = next_st.level >= nf_level;
			next_st.ne = next_st.level <= {1'b0, st.ctrl.fifo_margin_level};
			next_st.hf = next_st.level >= LVL_HALF;
		end
		events[INT_NEAR_FULL] = next_st.nf & ~st.nf;
		events[INT_NEAR_EMPTY] = next_st.ne & ~st.ne;

		// Phase accumulator: 27 ticks every 40 system clocks on average
		nco_sum = {1'b0, st.nco} + NCO_STEP;
		tick = nco_sum >= NCO_MOD;
		next_st.nco = tick ? NCO_W'(nco_sum - NCO_MOD) : NCO_W'(nco_sum);

		// Genlock word is reloaded after its last bit has shifted out
		if (st.genlock_cnt == '0) begin
			next_st.genlock_shift = i_genlock_word;
			next_st.genlock_cnt = GENLOCK_LAST;
		end else begin
			next_st.genlock_shift = {st.genlock_shift[GENLOCK_W-2:0], 1'b0};
			next_st.genlock_cnt = GENLOCK_CNT_W'(st.genlock_cnt - 1'b1);
		end

		// Register writes; hardware events win over a write-one clear
		if (i_bus.wr) begin
			unique case (i_bus.addr)
				REG_CTRL: next_st.ctrl = vofl_ctrl_t'(i_bus.wdata[CTRL_W-1:0]);
				REG_INT_MASK: next_st.int_mask = i_bus.wdata[INT_W-1:0];
				REG_INT_STAT: next_st.int_stat = st.int_stat & ~i_bus.wdata[INT_W-1:0];
				default: ;
			endcase
		end
		next_st.int_stat = next_st.int_stat | events;
		next_st.irq = |(next_st.int_stat & next_st.int_mask);

		// Power state and pins
		next_st.pwr = down ? VOFL_PWR_DOWN : VOFL_PWR_RUN;
		if (down) begin
			// Contents are dropped: the decoder restarts its stream after wake-up
			next_st.wr_ptr = '0;
			next_st.rd_ptr = '0;
			next_st.level = LVL_EMPTY;
			next_st.nf = 1'b0;
			next_st.ne = 1'b1;
			next_st.hf = 1'b0;
			next_st.pins = '0;
		end else begin
			next_st.pins.fifo_near_full_flag = next_st.nf ^ ~next_st.ctrl.flag_polarity_select;
			next_st.pins.fifo_near_empty_flag = next_st.ne ^ ~next_st.ctrl.flag_polarity_select;
			next_st.pins.half_line_locked_clock = st.pins.half_line_locked_clock ^ tick;
			next_st.pins.half_rate_qualifier =
				next_st.pins.half_line_locked_clock ^ ~next_st.ctrl.qualifier_polarity_select;
			// Limitation: a 40 MHz register cannot toggle at 27 MHz, so the
			// line-locked mode sends the tick train and FIFO mode runs at 20 MHz
			if (next_st.ctrl.fifo_clock_mode) begin
				next_st.pins.line_locked_clock = ~st.pins.line_locked_clock;
			end else begin
				next_st.pins.line_locked_clock = tick;
			end
			next_st.pins.multi_oe = 1'b1;
			unique case (next_st.ctrl.output_mode_select)
				VOFL_MODE_HALF: next_st.pins.multi_pin = next_st.hf ^ ~next_st.ctrl.flag_polarity_select;
				VOFL_MODE_QUAL: next_st.pins.multi_pin = pop;
				VOFL_MODE_GENLOCK: next_st.pins.multi_pin = next_st.genlock_shift[GENLOCK_W-1];
				VOFL_MODE_RSVD: begin
					next_st.pins.multi_pin = 1'b0;
					next_st.pins.multi_oe = 1'b0;
				end
			endcase
		end

		// Read data valid only in the cycle after the read strobe
		status = {sync_lvl[SYNC_PIN], st.pwr == VOFL_PWR_DOWN, st.hf, st.ne, st.nf, st.level};
		next_st.rdata = '0;
		if (i_bus.rd) begin
			unique case (i_bus.addr)
				REG_CTRL: next_st.rdata = DATA_W'(st.ctrl);
				REG_STATUS: next_st.rdata = DATA_W'(status);
				REG_INT_STAT: next_st.rdata = DATA_W'(st.int_stat);
				REG_INT_MASK: next_st.rdata = DATA_W'(st.int_mask);
				default: next_st.rdata = '0;
			endcase
		end
	end

	// ***********************************************************************
	// State register
	// ***********************************************************************
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			st <= '0;
			st.ctrl <= CTRL_RESET;
			st.ne <= 1'b1;
			st.pins <= PINS_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;
	assign o_irq = st.irq;
	assign o_pixel_output_bus = st.pix_out;
	assign o_pins = st.pins;

	// ***********************************************************************
	// Checks
	// ***********************************************************************
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_srst);

	sequence pop_seq;
		pop && st.ctrl.output_mode_select == VOFL_MODE_QUAL;
	endsequence
	sequence down_seq;
		down [*2];
	endsequence

	near_full_level_a: assert property ((rd_rise && !down) |=> st.nf == (st.level >= $past(nf_level)))
		else $error("near-full flag does not match fill level");
	near_empty_level_a: assert property ((rd_rise && !down)
		|=> st.ne == (st.level <= {1'b0, $past(st.ctrl.fifo_margin_level)}))
		else $error("near-empty flag does not match fill level");
	flag_polarity_a: assert property ((st.pwr == VOFL_PWR_RUN)
		|-> o_pins.fifo_near_empty_flag == (st.ne ^ ~st.ctrl.flag_polarity_select))
		else $error("near-empty pin polarity wrong");
	half_pin_a: assert property ((st.pwr == VOFL_PWR_RUN && st.ctrl.output_mode_select == VOFL_MODE_HALF)
		|-> o_pins.multi_oe && o_pins.multi_pin == (st.hf ^ ~st.ctrl.flag_polarity_select))
		else $error("shared pin does not carry half-level flag");
	qual_pulse_a: assert property (pop_seq ##1 !down |-> o_pins.multi_pin ##1 (o_pins.multi_pin == $past(pop)))
		else $error("qualified clock missing after pixel read");
	genlock_pin_a: assert property ((st.pwr == VOFL_PWR_RUN && st.ctrl.output_mode_select == VOFL_MODE_GENLOCK)
		|-> o_pins.multi_pin == st.genlock_shift[GENLOCK_W-1])
		else $error("shared pin does not carry genlock stream");
	pixel_read_a: assert property (pop |=> o_pixel_output_bus == $past(st.mem[st.rd_ptr]))
		else $error("pixel bus not loaded from FIFO head");
	qualifier_pol_a: assert property ((st.pwr == VOFL_PWR_RUN) |-> o_pins.half_rate_qualifier
		== (o_pins.half_line_locked_clock ^ ~st.ctrl.qualifier_polarity_select))
		else $error("qualifier polarity wrong");
	half_clock_a: assert property ((tick && !down && st.pwr == VOFL_PWR_RUN)
		|=> o_pins.half_line_locked_clock != $past(o_pins.half_line_locked_clock))
		else $error("half clock did not toggle on tick");
	fifo_clock_a: assert property ((!down && st.pwr == VOFL_PWR_RUN && st.ctrl.fifo_clock_mode && !i_bus.wr)
		|=> o_pins.line_locked_clock != $past(o_pins.line_locked_clock))
		else $error("FIFO output clock did not toggle");
	power_down_a: assert property (down_seq |=> st.pwr == VOFL_PWR_DOWN && !o_pins.multi_oe
		&& st.level == LVL_EMPTY)
		else $error("power-down not entered");
	flags_hold_a: assert property ((!rd_rise && !down) |=> $stable({st.nf, st.ne, st.hf}))
		else $error("flag changed without read clock edge");
	irq_level_a: assert property (o_irq == |(st.int_stat & st.int_mask))
		else $error("interrupt output disagrees with status and mask");

endmodule : vofl_top

// ---- vofl_reader.sv ----
/*
 * Model of the receiving video logic: it makes the slow read clock and drives power-down.
 * Assumes one i_mclk domain on the bench; edge requests arrive as one-cycle pulses, sleep as a held level.
 */
module vofl_reader (
	// Clock and requests from the bench
	input wire logic i_mclk,
	input wire logic i_edge_req,
	input wire logic i_sleep,
	// Pins toward the device
	output logic o_fifo_read_clock,
	output logic o_power_down_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ***********************************************************************
	// Read clock
	// ***********************************************************************
	logic [3:0] phase = 4'h0;
	// Four cycles per half period so the device's synchroniser never misses an edge
	always_ff @(posedge i_mclk) begin
		if (phase == 4'h8)
			phase <= 4'h0;
		else if (phase != 4'h0 || i_edge_req)
			phase <= phase + 4'h1;
	end
	// Clock stands low between requested cycles
	assign o_fifo_read_clock = (phase != 4'h0) && (phase <= 4'h4);
	assign o_power_down_n = !i_sleep;
endmodule : vofl_reader

// ---- test_video_output_fifo_flags.sv ----
/*
 * Self-checking bench of the output FIFO flag block with a reader model.
 * Assumes the design package and a control reset value of 0x1A4.
 */
module test_video_output_fifo_flags;
	import vofl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// ***********************************************************************
	// Signals
	// ***********************************************************************
	logic mclk = 1'b0;
	logic srst = 1'b1;
	vofl_bus_req_t bus = '0;
	logic [DATA_W-1:0] rdata;
	logic irq;
	vofl_pix_t pix = '0;
	logic [GENLOCK_W-1:0] genlock_word = 24'h000000;
	logic pin_in = 1'b0;
	logic rd_clk, pd_n, edge_req = 1'b0, sleep = 1'b0;
	logic [PIX_W-1:0] pbus;
	vofl_pins_t pins;
	int errors = 0, n_compared = 0, cycles = 0, qpulses = 0;
	logic [DATA_W-1:0] d;
	int tog, same, llc;
	typedef struct {logic [ADDR_W-1:0] a; logic [DATA_W-1:0] w; logic [DATA_W-1:0] e;} vofl_row_t;
	vofl_row_t rows[4] = '{'{REG_CTRL, 32'hFFFFFFFF, 32'h000003FF}, '{REG_INT_MASK, 32'hFFFFFFFF, 32'h0000000F},
		'{REG_STATUS, 32'hFFFFFFFF, 32'h00000080}, '{8'h10, 32'hFFFFFFFF, 32'h00000000}};

	vofl_top dut (.i_mclk(mclk), .i_srst(srst), .i_bus(bus), .o_rdata(rdata), .o_irq(irq), .i_pix(pix),
		.i_genlock_word(genlock_word), .i_fifo_read_clock(rd_clk), .i_power_down_n(pd_n), .i_multi_pin(pin_in),
		.o_pixel_output_bus(pbus), .o_pins(pins));
	vofl_reader reader (.i_mclk(mclk), .i_edge_req(edge_req), .i_sleep(sleep), .o_fifo_read_clock(rd_clk),
		.o_power_down_n(pd_n));

	initial begin
		forever #12.5 mclk = ~mclk;
	end
	// Counted on the falling edge, where the registered pin has settled
	always @(negedge mclk) begin
		if (pins.multi_pin === 1'b1)
			qpulses++;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("[FAIL] %0t run did not finish", $time);
			tally_and_finish();
		end
	end
	// ***********************************************************************
	// Tasks
	// ***********************************************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w);
		@(posedge mclk);
		bus <= {1'b1, 1'b0, a, w};
		@(posedge mclk);
		bus <= '0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
		@(posedge mclk);
		bus <= {1'b0, 1'b1, a, 32'h00000000};
		@(posedge mclk);
		bus <= '0;
		#1 q = rdata;
	endtask : rd
	task automatic push(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			pix <= {1'b1, 20'hA0000 + 20'(i)};
		end
		@(posedge mclk);
		pix <= '0;
	endtask : push
	// Sync and edge detect settle within five cycles of the read clock rise
	task automatic pop();
		@(posedge mclk);
		edge_req <= 1'b1;
		@(posedge mclk);
		edge_req <= 1'b0;
		repeat (12) @(posedge mclk);
		#1;
	endtask : pop
	task automatic measure(input logic [DATA_W-1:0] c);
		logic prev;
		wr(REG_CTRL, c);
		repeat (4) @(posedge mclk);
		#1 prev = pins.half_line_locked_clock;
		tog = 0;
		same = 0;
		llc = 0;
		repeat (400) begin
			@(posedge mclk);
			#1;
			tog += int'(pins.half_line_locked_clock !== prev);
			same += int'(pins.half_rate_qualifier === pins.half_line_locked_clock);
			llc += int'(pins.line_locked_clock === 1'b1);
			prev = pins.half_line_locked_clock;
		end
	endtask : measure
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// ***********************************************************************
	// Sequence
	// ***********************************************************************
	initial begin
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, d);
			check(d, rows[i].e, "register row");
		end
		wr(REG_CTRL, 32'h000001A4);
		wr(REG_INT_MASK, 32'h00000000);
		$display("test registers done");
		push(33);
		#1 check(32'(pins.fifo_near_empty_flag), 1, "flag moved without read edge");
		pop();
		check(32'(pbus), 32'h000A0000, "first word");
		check(32'({pins.fifo_near_full_flag, pins.fifo_near_empty_flag, pins.multi_pin}), 5, "flags high");
		wr(REG_CTRL, 32'h00000184);
		pop();
		check(32'({pins.fifo_near_full_flag, pins.fifo_near_empty_flag, pins.multi_pin}), 2, "flags low");
		rd(REG_STATUS, d);
		check(d, 32'h0000015E, "status at 30");
		rd(REG_INT_STAT, d);
		check(d, 32'h00000005, "events");
		check(32'(irq), 0, "masked irq");
		wr(REG_INT_MASK, 32'h00000004);
		repeat (2) @(posedge mclk);
		#1 check(32'(irq), 1, "irq raised");
		wr(REG_INT_STAT, 32'h00000005);
		repeat (2) @(posedge mclk);
		#1 check(32'(irq), 0, "irq cleared");
		for (int k = 0; k < 26; k++) begin
			if (k == 25)
				check(32'(pins.fifo_near_empty_flag), 1, "near empty at 5");
			pop();
		end
		check(32'(pins.fifo_near_empty_flag), 0, "near empty at 4");
		check(32'(pbus), 32'h000A001B, "fifo order");
		$display("test flags done");
		wr(REG_CTRL, 32'h00000164);
		qpulses = 0;
		pop();
		check(32'(qpulses), 1, "qualified clock pulse");
		@(posedge mclk) genlock_word <= 24'hFFFFFF;
		wr(REG_CTRL, 32'h00000124);
		repeat (60) @(posedge mclk);
		#1 check(32'({pins.multi_pin, pins.multi_oe}), 3, "genlock ones");
		@(posedge mclk) genlock_word <= 24'h000000;
		repeat (60) @(posedge mclk);
		#1 check(32'({pins.multi_pin, pins.multi_oe}), 1, "genlock zeros");
		wr(REG_CTRL, 32'h000001E4);
		repeat (2) @(posedge mclk);
		#1 check(32'(pins.multi_oe), 0, "pin released");
		$display("test modes done");
		measure(32'h000001A4);
		check(32'(tog >= 269 && tog <= 271), 1, "half clock rate");
		check(32'(same), 400, "qualifier true");
		check(32'(llc >= 269 && llc <= 271), 1, "line clock ticks");
		measure(32'h000000A4);
		check(32'(same), 0, "qualifier inverted");
		measure(32'h000003A4);
		check(32'(llc), 200, "fifo clock");
		$display("test clocks done");
		@(posedge mclk);
		sleep <= 1'b1;
		pin_in <= 1'b1;
		repeat (8) @(posedge mclk);
		#1 check(32'(pins), 0, "pins in power down");
		rd(REG_STATUS, d);
		check(32'(d[9]), 1, "power down status");
		check(32'(d[10]), 1, "shared pin input");
		@(posedge mclk);
		sleep <= 1'b0;
		pin_in <= 1'b0;
		repeat (8) @(posedge mclk);
		pop();
		rd(REG_INT_STAT, d);
		check(d, 32'h0000000A, "underflow event");
		$display("test power down done");
		push(3);
		srst <= 1'b1;
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		#1 check(32'(pins), 32'h00000028, "pins after reset");
		check(32'({irq, pbus}), 0, "outputs after reset");
		rd(REG_CTRL, d);
		check(d, 32'h000001A4, "control after reset");
		$display("test reset done");
		tally_and_finish();
	end
endmodule : test_video_output_fifo_flags
